//--- common/alarm_cal_defines.svh
// Register offsets, field positions, reset values and output codes.
// Assumes a 12-bit APB byte address and 12-bit analog output converters.
`ifndef ALARM_CAL_DEFINES_SVH
`define ALARM_CAL_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CFG 12'h000
`define OFS_THR1 12'h004
`define OFS_THR2 12'h008
`define OFS_CONC 12'h00C
`define OFS_CMD 12'h010
`define OFS_STATUS 12'h014

// ****************************************
// Field positions
// ****************************************
`define CFG_AL1_LSB 0
`define CFG_AL2_LSB 4
`define CFG_VALVE_BIT 8
`define CFG_RANGE_LSB 9
`define CMD_DONE_BIT 0
`define CMD_CLR_BIT 1
`define CMD_KEY_PWR_BIT 2
`define CMD_KEY_SYS_BIT 3
`define CMD_KEY_OTHER_BIT 4

// ****************************************
// Reset values
// ****************************************
`define CFG_RST 11'h000
`define THR_RST 16'h0000
`define CONC_RST 16'h0000

// ****************************************
// Output codes, full code 12'hFFF = 1 V or 20 mA
// ****************************************
`define VID_LOW 12'h400
`define VID_MED 12'h800
`define VID_HIGH 12'hC00
`define IID_LOW 12'h666
`define IID_MED 12'h999
`define IID_HIGH 12'hCCC
`define CUR_ZERO 12'h333
`define CUR_SPAN 12'hCCC

`endif

//--- common/alarm_cal_pkg.sv
// Types shared by the alarm and remote calibration control block.
// Assumes the defines header is on the include path.
package alarm_cal_pkg;
   // ****************************************
   // Enumerations
   // ****************************************
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_ZERO = 2'b01,
      CAL_SPAN = 2'b10
   } cal_state_t;
   typedef enum logic [1:0] {
      RNG_LOW = 2'b00,
      RNG_MED = 2'b01,
      RNG_HIGH = 2'b10
   } range_t;
   typedef enum logic [1:0] {
      SYS_ARMED = 2'b00,
      SYS_PWR_OFF = 2'b01,
      SYS_PWR_ON = 2'b11
   } sys_step_t;

   // ****************************************
   // Carriers and state records
   // ****************************************
   typedef struct packed {
      logic latch;
      logic failsafe;
      logic high;
      logic en;
   } alarm_cfg_t;
   typedef struct packed {
      logic al1;
      logic al2;
      logic sys;
   } relay_t;
   typedef struct packed {
      logic zero;
      logic span;
      logic sample;
   } valve_t;
   typedef struct packed {
      logic [11:0] conc_v;
      logic [11:0] conc_i;
      logic [11:0] id_v;
      logic [11:0] id_i;
   } dac_t;
   typedef struct packed {
      logic active;
      logic relay;
   } chan_state_t;
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
      logic [1:0] level;
   } filt_state_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [10:0] cfg;
      logic [15:0] thr1;
      logic [15:0] thr2;
      logic [15:0] conc;
      cal_state_t cal;
      logic busy;
      logic sys_lat;
      sys_step_t step;
      logic cal_done;
      logic alm_clr;
      relay_t relay;
      valve_t valve;
      dac_t dac;
   } ctl_state_t;
endpackage

//--- src/alarm_cal_ctrl.sv
// Alarm relays, analog output codes and remote calibration handshake.
// System alarm has no configuration path.
// Assumes an APB master on ref_clk, supply and self-test flags
// from logic on the same clock, and remote inputs straight from pins.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "alarm_cal_defines.svh"

// Contract
// - Threshold alarm is high type above threshold, low type below it.
// - Each threshold alarm selects failsafe or plain relay polarity.
// - Each threshold alarm selects latching or following behaviour.
// - A disabled threshold alarm never actuates its relay.
// - System alarm asserts when the supply monitor flags a fault.
// - System alarm is fixed failsafe and latching, never disabled.
// - System alarm also asserts on a self test failure.
// - System latch clears after power off, power on, non-system key.
// - Voltage range identity is 0.25, 0.5 or 0.75 V by range.
// - Current range identity is 8, 12 or 16 mA by range.
// - Voltage concentration output scales 0 V to 1 V full scale.
// - Current concentration output scales 4 mA to 20 mA.
// - Remote zero enters zero calibration, remote span enters span.
// - Controller drops request; calibration ends when done.
// - With internal valves fitted the block drives all three valves.
// - Calibration contact closed exactly while calibrating.
// - With contact open the block analyses and polls requests.
// - Requests during calibration are ignored and not remembered.
// - A request still held at completion restarts calibration.
module alarm_cal_ctrl
   import alarm_cal_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic remote_zero,
   input wire logic remote_span,
   input wire logic supply_fault,
   input wire logic selftest_fail,
   output relay_t alarm_relay,
   output valve_t valve,
   output dac_t dac,
   output logic cal_contact
);
   // Block state and its next value
   ctl_state_t st;
   ctl_state_t next_st;

   // Filtered requests, bit 0 zero
   logic [1:0] req;

   // Threshold channel results
   logic al1_active;
   logic al2_active;
   logic al1_relay;
   logic al2_relay;

   // Bus decode and read path
   logic access;
   logic wr_go;
   logic mapped;
   logic [31:0] rd_word;

   // Command strobes of this write
   logic [31:0] cmd;

   // Anything that trips the system alarm
   logic fault;

   // ****************************************
   // Helper functions
   // ****************************************

   // Word offset hit within the decoded register window
   // Byte lanes ignored, one word each
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] ofs);
      hit = (a[11:2] == ofs[11:2]);
   endfunction

   // Voltage range identity code
   function automatic logic [11:0] id_volt(input logic [1:0] r);
      case (r)
         RNG_LOW: id_volt = `VID_LOW;
         RNG_MED: id_volt = `VID_MED;
         RNG_HIGH: id_volt = `VID_HIGH;
         default: id_volt = `VID_HIGH;
      endcase
   endfunction

   // Current range identity code
   function automatic logic [11:0] id_curr(input logic [1:0] r);
      case (r)
         RNG_LOW: id_curr = `IID_LOW;
         RNG_MED: id_curr = `IID_MED;
         RNG_HIGH: id_curr = `IID_HIGH;
         default: id_curr = `IID_HIGH;
      endcase
   endfunction

   // Fraction of full scale onto the 4..20 mA code span
   // Half an LSB rounds full scale to top
   function automatic logic [11:0] loop_code(input logic [15:0] f);
      logic [27:0] prod;
      prod = 28'(f) * 28'(`CUR_SPAN) + 28'h0008000;
      loop_code = 12'(`CUR_ZERO + prod[27:16]);
   endfunction

   // ****************************************
   // Remote input conditioning and alarm channels
   // ****************************************
   // Three flops, two agreeing stages
   remote_in_filter u_filter (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin({remote_span, remote_zero}),
      .level(req)
   );

   // Alarm 1 on config bits 3..0
   alarm_channel u_al1 (
      .ref_clk(ref_clk),
      .rst(rst),
      .conc(st.conc),
      .thr(st.thr1),
      .cfg(alarm_cfg_t'(st.cfg[`CFG_AL1_LSB +: 4])),
      .clear(st.alm_clr),
      .active(al1_active),
      .relay(al1_relay)
   );

   // Alarm 2 on config bits 7..4
   alarm_channel u_al2 (
      .ref_clk(ref_clk),
      .rst(rst),
      .conc(st.conc),
      .thr(st.thr2),
      .cfg(alarm_cfg_t'(st.cfg[`CFG_AL2_LSB +: 4])),
      .clear(st.alm_clr),
      .active(al2_active),
      .relay(al2_relay)
   );

   // ****************************************
   // APB decode and read mux
   // ****************************************
   // Access phase of a transfer
   assign access = psel & penable;

   // Writes land at the answering edge
   assign wr_go = access & pwrite & st.pready;

   // Command bits act once, never stored
   assign cmd = wr_go & hit(paddr, `OFS_CMD) ? pwdata : 32'h00000000;

   // Flags already on this clock
   assign fault = supply_fault | selftest_fail;

   // Read data and map check
   always_comb begin
      rd_word = 32'h00000000;
      mapped = 1'b1;
      if (hit(paddr, `OFS_CFG)) begin
         rd_word[10:0] = st.cfg;
      end else if (hit(paddr, `OFS_THR1)) begin
         rd_word[15:0] = st.thr1;
      end else if (hit(paddr, `OFS_THR2)) begin
         rd_word[15:0] = st.thr2;
      end else if (hit(paddr, `OFS_CONC)) begin
         rd_word[15:0] = st.conc;
      end else if (hit(paddr, `OFS_CMD)) begin
         rd_word = 32'h00000000;
      end else if (hit(paddr, `OFS_STATUS)) begin
         // Status flags and filtered requests
         rd_word[0] = al1_active;
         rd_word[1] = al2_active;
         rd_word[2] = st.sys_lat;
         rd_word[3] = st.busy;
         rd_word[5:4] = st.cal;
         rd_word[6] = (st.step == SYS_PWR_OFF);
         rd_word[8:7] = req;
      end else begin
         mapped = 1'b0;
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_st = st;

      // Bus answer one cycle into the access phase
      // Error flag stands with pready
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      if (access && !st.pready) begin
         next_st.pready = 1'b1;
         next_st.prdata = mapped ? rd_word : 32'h00000000;
         next_st.pslverr = ~mapped;
      end

      // Register writes take effect at the answering edge
      // Unmapped writes are dropped
      if (wr_go && mapped) begin
         if (hit(paddr, `OFS_CFG)) begin
            next_st.cfg = pwdata[10:0];
         end
         if (hit(paddr, `OFS_THR1)) begin
            next_st.thr1 = pwdata[15:0];
         end
         if (hit(paddr, `OFS_THR2)) begin
            next_st.thr2 = pwdata[15:0];
         end
         if (hit(paddr, `OFS_CONC)) begin
            next_st.conc = pwdata[15:0];
         end
      end

      // Command strobes last one cycle
      next_st.cal_done = cmd[`CMD_DONE_BIT];
      next_st.alm_clr = cmd[`CMD_CLR_BIT];

      // Key sequence for the system latch
      case (st.step)
         SYS_ARMED: begin
            if (cmd[`CMD_KEY_PWR_BIT]) begin
               next_st.step = SYS_PWR_OFF;
            end
         end
         SYS_PWR_OFF: begin
            if (cmd[`CMD_KEY_PWR_BIT]) begin
               next_st.step = SYS_PWR_ON;
            end
         end
         SYS_PWR_ON: begin
            // Power again from on returns to off
            if (cmd[`CMD_KEY_PWR_BIT]) begin
               next_st.step = SYS_PWR_OFF;
            end else if (cmd[`CMD_KEY_OTHER_BIT] &&
                         !cmd[`CMD_KEY_SYS_BIT]) begin
               next_st.step = SYS_ARMED;
            end
         end
         default: begin
            next_st.step = SYS_ARMED;
         end
      endcase

      // System alarm latch, a new fault beats the clear
      // Only the key sequence clears it
      if (fault) begin
         next_st.sys_lat = 1'b1;
      end else if (st.step == SYS_PWR_ON && next_st.step == SYS_ARMED) begin
         next_st.sys_lat = 1'b0;
      end

      // Calibration sequencer, polled only while idle
      case (st.cal)
         CAL_IDLE: begin
            // A held request restarts from idle
            if (req[0]) begin
               next_st.cal = CAL_ZERO;
            end else if (req[1]) begin
               next_st.cal = CAL_SPAN;
            end
         end
         CAL_ZERO, CAL_SPAN: begin
            // Requests are not looked at here
            // Busy requests are not queued
            if (st.cal_done) begin
               next_st.cal = CAL_IDLE;
            end
         end
         default: begin
            next_st.cal = CAL_IDLE;
         end
      endcase
      next_st.busy = (next_st.cal != CAL_IDLE);

      // Internal valves only when the option is fitted
      // Option absent: valves left closed
      if (st.cfg[`CFG_VALVE_BIT]) begin
         next_st.valve.zero = (next_st.cal == CAL_ZERO);
         next_st.valve.span = (next_st.cal == CAL_SPAN);
         next_st.valve.sample = (next_st.cal == CAL_IDLE);
      end else begin
         next_st.valve = '0;
      end

      // Relay drive, system coil energised while healthy
      // Channels set their own polarity
      next_st.relay.al1 = al1_relay;
      next_st.relay.al2 = al2_relay;
      next_st.relay.sys = ~next_st.sys_lat;

      // Analog output codes
      // Top twelve bits of the fraction
      next_st.dac.conc_v = st.conc[15:4];
      next_st.dac.conc_i = loop_code(st.conc);
      // Unused range code reads as high
      next_st.dac.id_v = id_volt(st.cfg[`CFG_RANGE_LSB +: 2]);
      next_st.dac.id_i = id_curr(st.cfg[`CFG_RANGE_LSB +: 2]);
   end

   // ****************************************
   // State register
   // ****************************************
   // Everything back to idle, relays off
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.cfg <= `CFG_RST;
         st.thr1 <= `THR_RST;
         st.thr2 <= `THR_RST;
         st.conc <= `CONC_RST;
         st.cal <= CAL_IDLE;
         st.step <= SYS_ARMED;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign pready = st.pready;
   assign prdata = st.prdata;
   assign pslverr = st.pslverr;
   assign alarm_relay = st.relay;
   assign valve = st.valve;
   assign dac = st.dac;
   // Contact and busy share one flop
   assign cal_contact = st.busy;
endmodule

//--- src/alarm_channel.sv
// One configurable threshold alarm channel with relay drive.
// Assumes concentration and threshold share one unsigned scale.
`timescale 1ns/10ps
module alarm_channel
   import alarm_cal_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [15:0] conc,
   input wire logic [15:0] thr,
   input wire alarm_cfg_t cfg,
   input wire logic clear,
   output logic active,
   output logic relay
);
   chan_state_t st;
   chan_state_t next_st;
   logic trip;

   // ****************************************
   // Comparison, latch and relay polarity
   // ****************************************
   always_comb begin
      next_st = st;
      trip = cfg.high ? (conc > thr) : (conc < thr);
      if (!cfg.en) begin
         next_st.active = 1'b0;
      end else if (cfg.latch) begin
         next_st.active = trip | (st.active & ~clear);
      end else begin
         next_st.active = trip;
      end
      // Failsafe holds the coil energised while healthy
      next_st.relay = cfg.failsafe ? ~next_st.active
                                   : next_st.active;
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign active = st.active;
   assign relay = st.relay;
endmodule

//--- src/remote_in_filter.sv
// Synchroniser and level filter for the two remote calibration inputs.
// Assumes inputs arrive asynchronously from the connector pins.
`timescale 1ns/10ps
module remote_in_filter
   import alarm_cal_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [1:0] pin,
   output logic [1:0] level
);
   filt_state_t st;
   filt_state_t next_st;

   // ****************************************
   // Three-stage chain, level moves when stages two and three agree
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.s1 = pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.level = (~(st.s2 ^ st.s3) & st.s3) |
                      ((st.s2 ^ st.s3) & st.level);
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;
endmodule

//--- tb/alarm_cal_ctrl_sva.sv
// Assertion checker for the alarm and remote calibration block.
// Assumes it is bound onto alarm_cal_ctrl and sees only its ports.
`timescale 1ns/10ps
`include "alarm_cal_defines.svh"
module alarm_cal_ctrl_sva
   import alarm_cal_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic remote_zero,
   input wire logic remote_span,
   input wire logic supply_fault,
   input wire logic selftest_fail,
   input wire relay_t alarm_relay,
   input wire valve_t valve,
   input wire dac_t dac,
   input wire logic cal_contact
);
   // ****************************************
   // Helpers
   // ****************************************
   logic [3:0] since_done;
   wire logic done_wr = psel && penable && pready && pwrite &&
      paddr == `OFS_CMD && pwdata[0];

   // Cycles since the last calibration done write, saturating
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         since_done <= 4'hF;
      end else if (done_wr) begin
         since_done <= 4'h0;
      end else if (since_done != 4'hF) begin
         since_done <= since_done + 4'h1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_done_write;
      done_wr;
   endsequence
   sequence s_settled;
      !$past(rst);
   endsequence

   // ****************************************
   // Properties
   // ****************************************
   a_apb_wait: assert property (psel && penable && !pready |=> pready)
      else $error("bus answer late");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_sys_supply: assert property (
      supply_fault |-> ##[1:3] !alarm_relay.sys)
      else $error("supply fault did not trip");
   a_sys_selftest: assert property (
      selftest_fail |-> ##[1:3] !alarm_relay.sys)
      else $error("self test fault did not trip");
   a_sys_hold: assert property (
      $fell(alarm_relay.sys) |=> !alarm_relay.sys [*8])
      else $error("system alarm not latched");
   a_contact_cause: assert property (
      $rose(cal_contact) |-> $past(remote_zero || remote_span, 3))
      else $error("contact closed without request");
   a_done_ends: assert property (
      s_done_write |-> ##[1:5] !cal_contact)
      else $error("calibration did not end");
   a_fall_cause: assert property (
      $fell(cal_contact) |-> since_done <= 4'h5)
      else $error("contact opened without done");
   a_reopen_gap: assert property (
      $fell(cal_contact) && (remote_zero || remote_span) |->
      ##[1:8] cal_contact)
      else $error("held request did not restart");
   a_range_codes: assert property (s_settled |->
      (dac.id_v == `VID_LOW && dac.id_i == `IID_LOW) ||
      (dac.id_v == `VID_MED && dac.id_i == `IID_MED) ||
      (dac.id_v == `VID_HIGH && dac.id_i == `IID_HIGH))
      else $error("range identity codes wrong");
   a_cur_floor: assert property (
      s_settled |-> dac.conc_i >= `CUR_ZERO)
      else $error("current output below floor");
   a_valve_zero: assert property (
      $rose(valve.zero) |-> !valve.span ##[0:2] cal_contact)
      else $error("zero valve outside calibration");
endmodule

bind alarm_cal_ctrl alarm_cal_ctrl_sva chk (.ref_clk, .rst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
   .remote_zero, .remote_span, .supply_fault, .selftest_fail,
   .alarm_relay, .valve, .dac, .cal_contact);

//--- tb/alarm_cal_ctrl_tb.sv
// Self-checking bench for the alarm and remote calibration block.
// Assumes package, defines header, checker and controller model.
`timescale 1ns/10ps
`include "alarm_cal_defines.svh"
module alarm_cal_ctrl_tb import alarm_cal_pkg::*;;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, remote_zero, remote_span, cal_contact;
   logic supply_fault = 1'h0, selftest_fail = 1'h0, rogue = 1'h0;
   logic [1:0] go = 2'h0, keep = 2'h0;
   relay_t alarm_relay;
   valve_t valve;
   dac_t dac;
   int bad_count = 0, tests_run = 0;
   logic [3:0] nib [8] = '{4'h3, 4'h3, 4'h7, 4'h7, 4'h1, 4'h1, 4'h1, 4'h2};
   logic [15:0] cn [8] = '{16'h5000, 16'h4000, 16'h5000, 16'h3000,
      16'h3000, 16'h4000, 16'h5000, 16'h5000};
   logic ex [8] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
   logic [23:0] idt [3] = '{{`VID_LOW, `IID_LOW}, {`VID_MED, `IID_MED},
      {`VID_HIGH, `IID_HIGH}};

   always #2 ref_clk = ~ref_clk;

   alarm_cal_ctrl dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .remote_zero, .remote_span,
      .supply_fault, .selftest_fail, .alarm_relay, .valve, .dac,
      .cal_contact);
   remote_ctrl_model ctl (.ref_clk, .rst, .go, .keep, .rogue, .cal_contact,
      .pin({remote_span, remote_zero}), .ext_valve());

   // ****************************************
   // Tasks
   // ****************************************
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic hang;
      bad_count++;
      $display("Error at %0t: wait timed out", $time);
      test_done();
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // One bus transfer, held until ready
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      if (pready !== 1'h1) hang();
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'h0, a, 32'h0);
   endtask
   task automatic wait_contact(input logic v);
      int n;
      n = 0;
      while (cal_contact !== v && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      if (cal_contact !== v) hang();
   endtask
   task automatic hold_open;
      int c;
      c = 0;
      repeat (24) begin
         @(posedge ref_clk);
         if (cal_contact !== 1'h0) c++;
      end
      chk(c, 0);
   endtask
   task automatic pulse(input logic [1:0] g, input logic r);
      go <= g;
      rogue <= r;
      @(posedge ref_clk);
      go <= 2'h0;
      rogue <= 1'h0;
   endtask
   task automatic sys_clear;
      wr(`OFS_CMD, 32'h4);
      wr(`OFS_CMD, 32'h4);
      wr(`OFS_CMD, 32'h10);
      tick(3);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      tick(3);
      rst <= 1'h0;
      tick(6);
      chk(dac, {12'h000, `CUR_ZERO, `VID_LOW, `IID_LOW});
      chk({alarm_relay, cal_contact}, 4'h2);
      rd(`OFS_CFG);
      chk(q, 32'h0);
      rd(12'h018);
      chk({e, q}, 33'h100000000);
      $display("Test reset done");
      for (int r = 0; r < 3; r++) begin
         wr(`OFS_CFG, r << 9);
         tick(3);
         chk({dac.id_v, dac.id_i}, idt[r]);
      end
      wr(`OFS_CONC, 32'hFFFF);
      tick(3);
      chk({dac.conc_v, dac.conc_i}, 24'hFFFFFF);
      wr(`OFS_CONC, 32'h8000);
      tick(3);
      chk(dac.conc_v, 12'h800);
      wr(`OFS_CONC, 32'h0);
      tick(3);
      chk({dac.conc_v, dac.conc_i}, {12'h000, `CUR_ZERO});
      $display("Test analog done");
      wr(`OFS_THR1, 32'h4000);
      wr(`OFS_THR2, 32'h4000);
      for (int i = 0; i < 8; i++) begin
         wr(`OFS_CFG, {nib[i], nib[i]});
         wr(`OFS_CONC, cn[i]);
         tick(3);
         chk({alarm_relay.al1, alarm_relay.al2}, {ex[i], ex[i]});
      end
      wr(`OFS_CFG, 32'hBB);
      wr(`OFS_CONC, 32'h5000);
      wr(`OFS_CONC, 32'h3000);
      tick(3);
      chk({alarm_relay.al1, alarm_relay.al2}, 2'h3);
      wr(`OFS_CMD, 32'h2);
      tick(3);
      chk({alarm_relay.al1, alarm_relay.al2}, 2'h0);
      $display("Test threshold done");
      supply_fault <= 1'h1;
      tick(1);
      supply_fault <= 1'h0;
      tick(3);
      chk(alarm_relay.sys, 1'h0);
      rd(`OFS_STATUS);
      chk(q[2], 1'h1);
      wr(`OFS_CMD, 32'h10);
      wr(`OFS_CMD, 32'h4);
      rd(`OFS_STATUS);
      chk(q[6], 1'h1);
      wr(`OFS_CMD, 32'h4);
      wr(`OFS_CMD, 32'h8);
      tick(3);
      chk(alarm_relay.sys, 1'h0);
      sys_clear();
      chk(alarm_relay.sys, 1'h1);
      selftest_fail <= 1'h1;
      tick(1);
      selftest_fail <= 1'h0;
      tick(3);
      chk(alarm_relay.sys, 1'h0);
      sys_clear();
      chk(alarm_relay.sys, 1'h1);
      $display("Test system alarm done");
      wr(`OFS_CFG, 32'h100);
      tick(2);
      chk(valve, 3'h1);
      pulse(2'h1, 1'h0);
      wait_contact(1'h1);
      rd(`OFS_STATUS);
      chk(q[5:3], 3'h3);
      chk(valve, 3'h4);
      keep <= 2'h2;
      pulse(2'h2, 1'h1);
      tick(10);
      keep <= 2'h0;
      tick(4);
      wr(`OFS_CMD, 32'h1);
      wait_contact(1'h0);
      hold_open();
      $display("Test zero cal done");
      keep <= 2'h2;
      pulse(2'h3, 1'h0);
      wait_contact(1'h1);
      rd(`OFS_STATUS);
      chk(q[5:3], 3'h3);
      wr(`OFS_CMD, 32'h1);
      wait_contact(1'h0);
      wait_contact(1'h1);
      rd(`OFS_STATUS);
      chk(q[5:3], 3'h5);
      chk(valve, 3'h2);
      keep <= 2'h0;
      tick(2);
      wr(`OFS_CMD, 32'h1);
      wait_contact(1'h0);
      hold_open();
      $display("Test repeat cal done");
      test_done();
   end
endmodule

//--- tb/remote_ctrl_model.sv
// Behavioural process controller on the remote calibration pins.
// Assumes the bench pulses go for one cycle per request.
`timescale 1ns/10ps
module remote_ctrl_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [1:0] go,
   input wire logic [1:0] keep,
   input wire logic rogue,
   input wire logic cal_contact,
   output logic [1:0] pin,
   output logic [1:0] ext_valve
);
   // ****************************************
   // Request handshake
   // ****************************************
   logic [1:0] pend;

   // External gas valves follow the commands
   assign ext_valve = pin;

   // Request while open, release once acknowledged
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pend <= 2'h0;
         pin <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (go[i] && rogue) begin
               pin[i] <= 1'h1; // Deliberate request while busy
            end else if (go[i]) begin
               pend[i] <= 1'h1;
            end else if (pend[i] && !cal_contact && !pin[i]) begin
               pin[i] <= 1'h1;
            end else if (pin[i] && cal_contact && !keep[i]) begin
               pin[i] <= 1'h0;
               pend[i] <= 1'h0;
            end
         end
      end
   end
endmodule
